// file: pkg/ufd_pkg.sv
// Purpose: Shared constants and types of the serial transceiver status, flag and divisor block.
// Assumes: 32-bit Avalon-MM word registers, 16x oversampling, one 100 MHz clock.
// Notes:   Offsets are byte addresses; the bus address port carries word indices.
//
// Overview of operation
// - Status register shows errors of last-read character.
// - Overrun status bit 3 rises immediately.
// - Overrun sets on full; clears on next store.
// - Bit 2 flags line low whole frame.
// - Break stores one zero character, waits idle.
// - Bit 1 flags parity mismatch per settings.
// - Bit 0 flags stop bit not one.
// - FIFO mode errors follow head character.
// - Flag bit 7 transmit empty, resets one.
// - Flag bit 6 receive full.
// - Flag bit 5 transmit full.
// - Flag bit 4 receive empty.
// - Flag bit 3 busy until stop bits sent.
// - Busy rises with transmit data, enabled or not.
// - Flag bit 0 is inverted clear-to-send input.
// - Flag bits 8, 2, 1 unsupported, read zero.
// - Infrared register ignores writes, reads zero.
// - Integer divisor sixteen bits, resets zero.
// - FIFO enable off gives one-entry holding registers.
// - Divisor is integer plus fraction, sixteen-times clock.
// - New divisor applies after current character.
package ufd_pkg;

    localparam int          UFD_DW        = 32;
    localparam int          UFD_AW        = 6;
    localparam int          UFD_FIFO_DEPTH = 16;

    // Byte offsets of the registers.
    localparam logic [7:0]  OFS_DATA      = 8'h00;
    localparam logic [7:0]  OFS_RX_STATUS = 8'h04;
    localparam logic [7:0]  OFS_FLAGS     = 8'h18;
    localparam logic [7:0]  OFS_IR_LP     = 8'h20;
    localparam logic [7:0]  OFS_DIV_INT   = 8'h24;
    localparam logic [7:0]  OFS_DIV_FRAC  = 8'h28;
    localparam logic [7:0]  OFS_LINE_CTRL = 8'h2c;
    localparam logic [7:0]  OFS_CTRL      = 8'h30;

    // Receive status bits; the data register carries them shifted up by eight.
    localparam int          STS_OVR       = 3;
    localparam int          STS_BRK       = 2;
    localparam int          STS_PAR       = 1;
    localparam int          STS_FRM       = 0;
    localparam int          DATA_STS_LSB  = 8;

    // Flag register bits.
    localparam int          FLG_TX_EMPTY  = 7;
    localparam int          FLG_RX_FULL   = 6;
    localparam int          FLG_TX_FULL   = 5;
    localparam int          FLG_RX_EMPTY  = 4;
    localparam int          FLG_BUSY      = 3;
    localparam int          FLG_CTS       = 0;

    // Line control bits.
    localparam int          LC_SPS        = 7;
    localparam int          LC_WLEN_HI    = 6;
    localparam int          LC_WLEN_LO    = 5;
    localparam int          LC_FEN        = 4;
    localparam int          LC_STP2       = 3;
    localparam int          LC_EPS        = 2;
    localparam int          LC_PEN        = 1;
    localparam int          LC_BRK        = 0;

    // Control bits.
    localparam int          CT_EN         = 0;
    localparam int          CT_TXE        = 8;
    localparam int          CT_RXE        = 9;

    // Reset values.
    localparam logic [15:0] DIV_INT_RST   = 16'h0000;
    localparam logic [5:0]  DIV_FRAC_RST  = 6'h00;
    localparam logic [7:0]  LINE_CTRL_RST = 8'h00;
    localparam logic [15:0] CTRL_RST      = 16'h0300;

    // Oversampling: sixteen ticks per bit, sample at the eighth.
    localparam logic [3:0]  TICK_LAST     = 4'hf;
    localparam logic [3:0]  TICK_MID      = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_PAR   = 3'b011,
        ST_STOP  = 3'b100,
        ST_BRKW  = 3'b101
    } ufd_bit_state_e;

    typedef struct packed {
        logic       brk;
        logic       par;
        logic       frm;
        logic [7:0] data;
    } ufd_rx_entry_s;

endpackage

// file: hw/ufd_top.sv
// Purpose: Serial transceiver core with receive status, flags and baud divisor registers.
// Assumes: Avalon-MM slave with one wait state per access; RXD and CTS_N are asynchronous.
// Notes:   Status and flags are software views; no interrupt or DMA logic lives here.
`timescale 1ns/1ps
module ufd_top #(
    parameter int DEPTH = ufd_pkg::UFD_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                         REF_CLK,
    input  wire logic                         RST,
    // Register bus
    input  wire logic [ufd_pkg::UFD_AW-1:0]   AV_ADDRESS,
    input  wire logic                         AV_READ,
    input  wire logic                         AV_WRITE,
    input  wire logic [ufd_pkg::UFD_DW-1:0]   AV_WRITEDATA,
    input  wire logic [3:0]                   AV_BYTEENABLE,
    output logic      [ufd_pkg::UFD_DW-1:0]   AV_READDATA,
    output logic                              AV_WAITREQUEST,
    // Serial line
    input  wire logic                         RXD,
    output logic                              TXD,
    input  wire logic                         CTS_N
);
    import ufd_pkg::*;

    localparam int PW = $clog2(DEPTH);

    function automatic logic hit(input logic [UFD_AW-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs[7:2]);
    endfunction

    // Parity bit for the configured word length, used by both directions.
    function automatic logic par_of(input logic [7:0] d, input logic [1:0] wl,
                                    input logic even_parity_select, input logic stick_parity_select);
        logic [7:0] m;
        m = 8'hff >> (2'd3 - wl);
        par_of = stick_parity_select ? ~even_parity_select : ((^(d & (m | 8'h1f))) ^ ~even_parity_select);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (o & ~m) | (n & m);
    endfunction

    // Input synchronisers.
    logic rxd_s1_reg, rxd_s2_reg, cts_s1_reg, cts_s2_reg;
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rxd_s1_reg <= 1'b1;
            rxd_s2_reg <= 1'b1;
            cts_s1_reg <= 1'b1;
            cts_s2_reg <= 1'b1;
        end else begin
            rxd_s1_reg <= RXD;
            rxd_s2_reg <= rxd_s1_reg;
            cts_s1_reg <= CTS_N;
            cts_s2_reg <= cts_s1_reg;
        end
    end

    // Register bus handshake: first cycle latches read data, second completes.
    logic        ack_reg, pop_ok_reg;
    logic [31:0] rdata_reg;
    wire         req     = AV_READ | AV_WRITE;
    wire         first   = req & ~ack_reg;
    wire         rd_acc  = AV_READ & ack_reg;
    wire         wr_acc  = AV_WRITE & ack_reg;
    assign AV_WAITREQUEST = first;
    assign AV_READDATA    = rdata_reg;

    wire hit_data = hit(AV_ADDRESS, OFS_DATA);
    wire hit_sts  = hit(AV_ADDRESS, OFS_RX_STATUS);
    wire hit_flg  = hit(AV_ADDRESS, OFS_FLAGS);
    wire hit_dint = hit(AV_ADDRESS, OFS_DIV_INT);
    wire hit_dfr  = hit(AV_ADDRESS, OFS_DIV_FRAC);
    wire hit_lc   = hit(AV_ADDRESS, OFS_LINE_CTRL);
    wire hit_ct   = hit(AV_ADDRESS, OFS_CTRL);

    // Software registers.
    logic [15:0] div_int_reg, div_int_act_reg, ctrl_reg;
    logic [5:0]  div_frac_reg, div_frac_act_reg;
    logic [7:0]  lc_reg;
    logic        ovr_reg, brk_reg, par_reg, frm_reg;

    wire        fifo_enable     = lc_reg[LC_FEN];
    wire [1:0]  wlen    = lc_reg[LC_WLEN_HI:LC_WLEN_LO];
    wire [2:0]  last_bit = 3'(wlen) + 3'd4;
    wire        rx_en   = ctrl_reg[CT_EN] & ctrl_reg[CT_RXE];
    wire        tx_en   = ctrl_reg[CT_EN] & ctrl_reg[CT_TXE];
    wire [PW:0] limit   = fifo_enable ? (PW+1)'(DEPTH) : (PW+1)'(1);

    // Receive FIFO.
    ufd_rx_entry_s rxf_mem [DEPTH];
    logic [PW-1:0] rxf_wp_reg, rxf_rp_reg;
    logic [PW:0]   rxf_cnt_reg;
    ufd_rx_entry_s rx_entry;
    logic          rx_push;
    wire           rx_empty = (rxf_cnt_reg == '0);
    wire           rx_full  = (rxf_cnt_reg >= limit);
    wire           rx_store = rx_push & ~rx_full;
    wire           rx_pop   = rd_acc & hit_data & pop_ok_reg;
    ufd_rx_entry_s rx_head;
    assign rx_head = rxf_mem[rxf_rp_reg];

    // Transmit FIFO.
    logic [7:0]    txf_mem [DEPTH];
    logic [PW-1:0] txf_wp_reg, txf_rp_reg;
    logic [PW:0]   txf_cnt_reg;
    logic          tx_pop;
    wire           tx_empty = (txf_cnt_reg == '0);
    wire           tx_full  = (txf_cnt_reg >= limit);
    wire           tx_push  = wr_acc & hit_data & ~tx_full;

    // Line engines.
    ufd_bit_state_e rx_st_reg, rx_st_next, tx_st_reg, tx_st_next;
    wire busy = ~tx_empty | (tx_st_reg != ST_IDLE);

    // Read multiplexer.
    logic [31:0] rmux;
    assign rmux =
        hit_data ? {20'h0, ovr_reg, rx_head.brk, rx_head.par, rx_head.frm,
                    rx_head.data} :
        hit_sts  ? {28'h0, ovr_reg, brk_reg, par_reg, frm_reg} :
        hit_flg  ? {24'h0, tx_empty, rx_full, tx_full, rx_empty, busy,
                    2'b00, ~cts_s2_reg} :
        hit_dint ? {16'h0, div_int_reg} :
        hit_dfr  ? {26'h0, div_frac_reg} :
        hit_lc   ? {24'h0, lc_reg} :
        hit_ct   ? {16'h0, ctrl_reg} :
                   32'h0;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ack_reg    <= 1'b0;
            pop_ok_reg <= 1'b0;
            rdata_reg  <= 32'h0;
        end else begin
            ack_reg <= first;
            if (first) begin
                rdata_reg  <= rmux;
                pop_ok_reg <= ~rx_empty;
            end
        end
    end

    // Software register writes; the infrared offset and unmapped words take no write.
    logic [31:0] wr_int, wr_frac, wr_lc, wr_ct;
    assign wr_int  = merge({16'h0, div_int_reg}, AV_WRITEDATA, AV_BYTEENABLE);
    assign wr_frac = merge({26'h0, div_frac_reg}, AV_WRITEDATA, AV_BYTEENABLE);
    assign wr_lc   = merge({24'h0, lc_reg}, AV_WRITEDATA, AV_BYTEENABLE);
    assign wr_ct   = merge({16'h0, ctrl_reg}, AV_WRITEDATA, AV_BYTEENABLE);
    wire   idle_both = (rx_st_reg == ST_IDLE) & (tx_st_reg == ST_IDLE);

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            div_int_reg      <= DIV_INT_RST;
            div_frac_reg     <= DIV_FRAC_RST;
            div_int_act_reg  <= DIV_INT_RST;
            div_frac_act_reg <= DIV_FRAC_RST;
            lc_reg           <= LINE_CTRL_RST;
            ctrl_reg         <= CTRL_RST;
        end else begin
            if (wr_acc & hit_dint) div_int_reg <= wr_int[15:0];
            if (wr_acc & hit_dfr) div_frac_reg <= wr_frac[5:0];
            if (wr_acc & hit_lc) lc_reg <= wr_lc[7:0];
            if (wr_acc & hit_ct) ctrl_reg <= wr_ct[15:0];
            if (idle_both) begin
                div_int_act_reg  <= div_int_reg;
                div_frac_act_reg <= div_frac_reg;
            end
        end
    end

    // Error status: break, parity and framing copy the character being read.
    wire sts_clr = wr_acc & hit_sts;
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ovr_reg <= 1'b0;
            brk_reg <= 1'b0;
            par_reg <= 1'b0;
            frm_reg <= 1'b0;
        end else begin
            // A lost character wins over a clear in the same cycle.
            if (rx_push & rx_full) ovr_reg <= 1'b1;
            else if (rx_store | sts_clr) ovr_reg <= 1'b0;
            if (rx_pop) begin
                brk_reg <= rx_head.brk;
                par_reg <= rx_head.par;
                frm_reg <= rx_head.frm;
            end else if (sts_clr) begin
                brk_reg <= 1'b0;
                par_reg <= 1'b0;
                frm_reg <= 1'b0;
            end
        end
    end

    // FIFO storage and pointers.
    always_ff @(posedge REF_CLK) begin
        if (rx_store) rxf_mem[rxf_wp_reg] <= rx_entry;
        if (tx_push) txf_mem[txf_wp_reg] <= AV_WRITEDATA[7:0];
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rxf_wp_reg  <= '0;
            rxf_rp_reg  <= '0;
            rxf_cnt_reg <= '0;
            txf_wp_reg  <= '0;
            txf_rp_reg  <= '0;
            txf_cnt_reg <= '0;
        end else begin
            if (rx_store) rxf_wp_reg <= PW'(rxf_wp_reg + 1'b1);
            if (rx_pop) rxf_rp_reg <= PW'(rxf_rp_reg + 1'b1);
            rxf_cnt_reg <= (PW+1)'(rxf_cnt_reg + rx_store - rx_pop);
            if (tx_push) txf_wp_reg <= PW'(txf_wp_reg + 1'b1);
            if (tx_pop) txf_rp_reg <= PW'(txf_rp_reg + 1'b1);
            txf_cnt_reg <= (PW+1)'(txf_cnt_reg + tx_push - tx_pop);
        end
    end

    // Sixteen-times tick: integer count plus a carry from the fraction accumulator.
    logic [15:0] bcnt_reg;
    logic [5:0]  facc_reg;
    wire  [6:0]  facc_sum = {1'b0, facc_reg} + {1'b0, div_frac_act_reg};
    wire         tick     = (div_int_act_reg != 16'h0) & (bcnt_reg == 16'h0);
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            bcnt_reg <= 16'h0;
            facc_reg <= 6'h0;
        end else if (tick) begin
            bcnt_reg <= 16'(div_int_act_reg - 16'h1 + {15'h0, facc_sum[6]});
            facc_reg <= facc_sum[5:0];
        end else if (idle_both & (div_int_act_reg != div_int_reg)) begin
            // Restart the count while idle, so a slow old divisor cannot hold off a new one.
            bcnt_reg <= 16'h0;
        end else if (bcnt_reg != 16'h0) begin
            bcnt_reg <= bcnt_reg - 16'h1;
        end
    end

    // Receiver.
    logic [3:0] rx_sub_reg, rx_sub_next;
    logic [2:0] rx_bit_reg, rx_bit_next;
    logic [7:0] rx_sh_reg, rx_sh_next;
    logic       rx_pb_reg, rx_pb_next;
    wire        rx_line  = rxd_s2_reg;
    wire        rx_samp  = tick & (rx_sub_reg == TICK_LAST);
    wire        rx_allz  = (rx_sh_reg == 8'h0) & (~lc_reg[LC_PEN] | ~rx_pb_reg);
    wire        rx_break = ~rx_line & rx_allz;
    wire        rx_perr  = lc_reg[LC_PEN] &
                           (rx_pb_reg != par_of(rx_sh_reg, wlen, lc_reg[LC_EPS],
                                                lc_reg[LC_SPS]));

    always_comb begin
        rx_st_next  = rx_st_reg;
        rx_sub_next = rx_sub_reg;
        rx_bit_next = rx_bit_reg;
        rx_sh_next  = rx_sh_reg;
        rx_pb_next  = rx_pb_reg;
        rx_push     = 1'b0;
        rx_entry    = '0;
        if (tick && rx_st_reg != ST_IDLE && rx_st_reg != ST_BRKW) rx_sub_next = rx_sub_reg + 4'h1;
        unique case (rx_st_reg)
            ST_IDLE: begin
                if (rx_en & tick & ~rx_line) begin
                    rx_st_next  = ST_START;
                    rx_sub_next = 4'h0;
                    rx_sh_next  = 8'h0;
                    rx_pb_next  = 1'b0;
                end
            end
            ST_START: begin
                if (tick && rx_sub_reg == TICK_MID) begin
                    rx_st_next  = rx_line ? ST_IDLE : ST_DATA;
                    rx_sub_next = 4'h0;
                    rx_bit_next = 3'h0;
                end
            end
            ST_DATA: begin
                if (rx_samp) begin
                    rx_sh_next[rx_bit_reg] = rx_line;
                    rx_bit_next = rx_bit_reg + 3'h1;
                    if (rx_bit_reg == last_bit) rx_st_next = lc_reg[LC_PEN] ? ST_PAR : ST_STOP;
                end
            end
            ST_PAR: begin
                if (rx_samp) begin
                    rx_pb_next = rx_line;
                    rx_st_next = ST_STOP;
                end
            end
            ST_STOP: begin
                if (rx_samp) begin
                    rx_push        = 1'b1;
                    rx_entry.data  = rx_break ? 8'h00 : rx_sh_reg;
                    rx_entry.brk   = rx_break;
                    rx_entry.par   = rx_perr & ~rx_break;
                    rx_entry.frm   = ~rx_line & ~rx_break;
                    rx_st_next     = rx_break ? ST_BRKW : ST_IDLE;
                end
            end
            ST_BRKW: begin
                // No further character until the line has returned to mark.
                if (rx_line) rx_st_next = ST_IDLE;
            end
            default: rx_st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rx_st_reg  <= ST_IDLE;
            rx_sub_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_sh_reg  <= 8'h0;
            rx_pb_reg  <= 1'b0;
        end else begin
            rx_st_reg  <= rx_st_next;
            rx_sub_reg <= rx_sub_next;
            rx_bit_reg <= rx_bit_next;
            rx_sh_reg  <= rx_sh_next;
            rx_pb_reg  <= rx_pb_next;
        end
    end

    // Transmitter.
    logic [3:0] tx_sub_reg, tx_sub_next;
    logic [2:0] tx_bit_reg, tx_bit_next;
    logic [7:0] tx_sh_reg, tx_sh_next;
    logic       txd_reg, txd_next;
    wire        tx_bend = tick & (tx_sub_reg == TICK_LAST);
    assign TXD = txd_reg;

    always_comb begin
        tx_st_next  = tx_st_reg;
        tx_sub_next = tick ? tx_sub_reg + 4'h1 : tx_sub_reg;
        tx_bit_next = tx_bit_reg;
        tx_sh_next  = tx_sh_reg;
        tx_pop      = 1'b0;
        unique case (tx_st_reg)
            ST_IDLE: begin
                tx_sub_next = 4'h0;
                if (tx_en & tick & ~tx_empty) begin
                    tx_pop      = 1'b1;
                    tx_sh_next  = txf_mem[txf_rp_reg];
                    tx_st_next  = ST_START;
                    tx_bit_next = 3'h0;
                end
            end
            ST_START: if (tx_bend) tx_st_next = ST_DATA;
            ST_DATA: begin
                if (tx_bend) begin
                    tx_bit_next = tx_bit_reg + 3'h1;
                    if (tx_bit_reg == last_bit) begin
                        tx_st_next  = lc_reg[LC_PEN] ? ST_PAR : ST_STOP;
                        tx_bit_next = 3'h0;
                    end
                end
            end
            ST_PAR: if (tx_bend) tx_st_next = ST_STOP;
            ST_STOP: begin
                // Busy holds through the last stop bit.
                if (tx_bend) begin
                    tx_bit_next = tx_bit_reg + 3'h1;
                    if (~lc_reg[LC_STP2] | tx_bit_reg[0]) tx_st_next = ST_IDLE;
                end
            end
            default: tx_st_next = ST_IDLE;
        endcase
    end

    always_comb begin
        unique case (tx_st_reg)
            ST_START: txd_next = 1'b0;
            ST_DATA:  txd_next = tx_sh_reg[tx_bit_reg];
            ST_PAR:   txd_next = par_of(tx_sh_reg, wlen, lc_reg[LC_EPS], lc_reg[LC_SPS]);
            default:  txd_next = 1'b1;
        endcase
        if (lc_reg[LC_BRK]) txd_next = 1'b0;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            tx_st_reg  <= ST_IDLE;
            tx_sub_reg <= 4'h0;
            tx_bit_reg <= 3'h0;
            tx_sh_reg  <= 8'h0;
            txd_reg    <= 1'b1;
        end else begin
            tx_st_reg  <= tx_st_next;
            tx_sub_reg <= tx_sub_next;
            tx_bit_reg <= tx_bit_next;
            tx_sh_reg  <= tx_sh_next;
            txd_reg    <= txd_next;
        end
    end

endmodule // ufd_top

// file: verif/ufd_top_properties.sv
// Purpose: Bus timing and register view properties of the status block.
// Assumes: One clock; read data is judged in the cycle waitrequest is low.
// Notes:   Sees only top-level ports; flag reads are decoded from the bus.
`timescale 1ns/1ps
module ufd_top_properties #(
    parameter int DEPTH = 16
) (
    input wire logic                       REF_CLK,
    input wire logic                       RST,
    input wire logic [ufd_pkg::UFD_AW-1:0] AV_ADDRESS,
    input wire logic                       AV_READ,
    input wire logic                       AV_WRITE,
    input wire logic [ufd_pkg::UFD_DW-1:0] AV_READDATA,
    input wire logic                       AV_WAITREQUEST,
    input wire logic                       TXD,
    input wire logic                       CTS_N
);
    import ufd_pkg::*;
    wire logic req     = AV_READ | AV_WRITE;
    wire logic rd_done = AV_READ & ~AV_WAITREQUEST;
    wire logic flg_rd  = rd_done & (AV_ADDRESS == 6'h06);
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    sequence req_start;
        $rose(req);
    endsequence
    // Two synchroniser flops plus the read latch fit inside five quiet cycles.
    sequence cts_quiet;
        $stable(CTS_N) [*5];
    endsequence
    AST_WAIT_FIRST: assert property (req_start |-> AV_WAITREQUEST)
        else $error("waitrequest low in first access cycle");
    AST_ONE_WAIT: assert property (req && AV_WAITREQUEST |=> !AV_WAITREQUEST)
        else $error("more than one wait state");
    AST_TXD_IDLE: assert property ($fell(RST) |-> TXD)
        else $error("serial output not idle after reset");
    AST_IR_ZERO: assert property (rd_done && AV_ADDRESS == 6'h08 |-> AV_READDATA == 32'h0)
        else $error("infrared register read not zero");
    AST_DIV_HIGH: assert property (rd_done && AV_ADDRESS == 6'h09 |-> AV_READDATA[31:16] == 16'h0)
        else $error("divisor upper bits not zero");
    AST_STS_HIGH: assert property (rd_done && AV_ADDRESS == 6'h01 |-> AV_READDATA[31:4] == 28'h0)
        else $error("status upper bits not zero");
    AST_CTS_INV: assert property (cts_quiet ##0 flg_rd |-> AV_READDATA[FLG_CTS] == ~CTS_N)
        else $error("clear-to-send flag not inverted input");
    AST_TXE_BUSY: assert property (flg_rd && !AV_READDATA[FLG_TX_EMPTY] |-> AV_READDATA[FLG_BUSY])
        else $error("transmit data held but not busy");
    AST_RX_EF: assert property (flg_rd |-> !(AV_READDATA[FLG_RX_EMPTY] && AV_READDATA[FLG_RX_FULL]))
        else $error("receive empty and full together");
endmodule // ufd_top_properties
bind ufd_top ufd_top_properties #(.DEPTH(DEPTH)) i_props (
    .REF_CLK(REF_CLK), .RST(RST), .AV_ADDRESS(AV_ADDRESS), .AV_READ(AV_READ),
    .AV_WRITE(AV_WRITE), .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST),
    .TXD(TXD), .CTS_N(CTS_N));

// file: verif/ufd_line_model.sv
// Purpose: Remote serial device on the receive and transmit lines.
// Assumes: BIT_CYC clock cycles per bit; line idles at mark level.
// Notes:   Frames are handed over ready made, so faults are chosen by the caller.
`timescale 1ns/1ps
module ufd_line_model #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk,
    output logic     rxd,
    input wire logic txd
);
    logic [7:0] got;
    initial rxd = 1'b1;
    // Sends n bits LSB first, then one bit time of mark so every frame ends idle.
    task automatic send(input logic [31:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rxd <= bits[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (BIT_CYC) @(posedge clk);
    endtask
    // Samples eight data bits at mid-bit after a start edge.
    task automatic grab();
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            got[i] = txd;
        end
    endtask
endmodule // ufd_line_model

// file: verif/ufd_top_test.sv
// Purpose: Register and line level test of the status, flag and divisor block.
// Assumes: Divisor 1 gives sixteen clocks per bit.
// Notes:   FIFOs stay off, so each direction holds one character, until the last receive test.
`timescale 1ns/1ps
module ufd_top_test;
    import ufd_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [5:0]  addr    = 6'h00;
    logic        rd      = 1'b0;
    logic        wr      = 1'b0;
    logic [31:0] wdata   = 32'h0;
    logic        cts_n   = 1'b1;
    logic [31:0] rdata;
    logic        wait_rq;
    logic        rxd;
    logic        txd;
    logic [31:0] q;
    logic [7:0]  lc_tab [3] = '{8'h66, 8'he6, 8'he2};
    logic [2:0]  p_tab   = 3'b110;
    logic [2:0]  e_tab   = 3'b011;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    always #5 ref_clk = ~ref_clk;
    ufd_top i_dut (.REF_CLK(ref_clk), .RST(rst), .AV_ADDRESS(addr), .AV_READ(rd),
        .AV_WRITE(wr), .AV_WRITEDATA(wdata), .AV_BYTEENABLE(4'hf), .AV_READDATA(rdata),
        .AV_WAITREQUEST(wait_rq), .RXD(rxd), .TXD(txd), .CTS_N(cts_n));
    ufd_line_model i_line (.clk(ref_clk), .rxd(rxd), .txd(txd));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // The request is held until the rising edge that sees waitrequest low; data is taken there.
    task automatic access(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= d;
        do @(posedge ref_clk); while (wait_rq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(6'h01, 32'h0);
        rd_chk(6'h06, 32'h90);
        rd_chk(6'h09, 32'h0);
        access(1'b1, 6'h08, 32'hffffffff);
        rd_chk(6'h08, 32'h0);
        access(1'b1, 6'h06, 32'h0);
        rd_chk(6'h06, 32'h90);
        rd_chk(6'h3f, 32'h0);
        access(1'b1, 6'h09, 32'hffffffff);
        rd_chk(6'h09, 32'h0000ffff);
        access(1'b1, 6'h09, 32'h1);
        access(1'b1, 6'h0b, 32'h60);
        access(1'b1, 6'h00, 32'h55);
        rd_chk(6'h06, 32'h38);
        fork
            i_line.grab();
            access(1'b1, 6'h0c, 32'h301);
        join
        check({24'h0, i_line.got}, 32'h55);
        rd_chk(6'h06, 32'h98);
        repeat (30) @(posedge ref_clk);
        rd_chk(6'h06, 32'h90);
        i_line.send({1'b1, 8'ha5, 1'b0}, 10);
        rd_chk(6'h06, 32'hc0);
        rd_chk(6'h00, 32'ha5);
        rd_chk(6'h01, 32'h0);
        i_line.send({1'b1, 8'h11, 1'b0}, 10);
        i_line.send({1'b1, 8'h22, 1'b0}, 10);
        rd_chk(6'h01, 32'h8);
        access(1'b0, 6'h00, 32'h0);
        check({24'h0, q[7:0]}, 32'h11);
        rd_chk(6'h01, 32'h8);
        i_line.send({1'b0, 8'h3c, 1'b0}, 10);
        rd_chk(6'h00, 32'h13c);
        rd_chk(6'h01, 32'h1);
        access(1'b1, 6'h01, 32'h0);
        rd_chk(6'h01, 32'h0);
        i_line.send(32'h0, 24);
        rd_chk(6'h00, 32'h400);
        rd_chk(6'h01, 32'h4);
        rd_chk(6'h06, 32'h90);
        i_line.send({1'b1, 8'h5a, 1'b0}, 10);
        rd_chk(6'h00, 32'h5a);
        for (int i = 0; i < 3; i++) begin
            access(1'b1, 6'h0c, 32'h300);
            access(1'b1, 6'h0b, {24'h0, lc_tab[i]});
            access(1'b1, 6'h0c, 32'h301);
            i_line.send({1'b1, p_tab[i], 8'h01, 1'b0}, 11);
            rd_chk(6'h00, {22'h0, e_tab[i], 9'h001});
            rd_chk(6'h01, {30'h0, e_tab[i], 1'b0});
        end
        access(1'b1, 6'h0b, 32'h70);
        i_line.send({1'b0, 8'h3c, 1'b0}, 10);
        i_line.send({1'b1, 8'h44, 1'b0}, 10);
        rd_chk(6'h06, 32'h80);
        rd_chk(6'h00, 32'h13c);
        rd_chk(6'h01, 32'h1);
        rd_chk(6'h00, 32'h44);
        rd_chk(6'h01, 32'h0);
        @(posedge ref_clk);
        cts_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd_chk(6'h06, 32'h91);
        conclude();
    end
endmodule // ufd_top_test
